// [hsld_defines.vh]
// Purpose: Shared constants of the strap latch and decoder.
// Assumes: Included by bare name from the decoder and strap latch files.
// Notes: Offsets are byte addresses on the register bus.
`ifndef HSLD_DEFINES_VH
`define HSLD_DEFINES_VH

// Register byte offsets
`define HSLD_ADDR_CTRL 5'h00
`define HSLD_ADDR_OVR 5'h04
`define HSLD_ADDR_STRAP 5'h08
`define HSLD_ADDR_CFG 5'h0C

// Control and override fields
`define HSLD_CTRL_OVR_EN 0
`define HSLD_OVR_PORT_LSB 0
`define HSLD_OVR_FIXED_LSB 8
`define HSLD_OVR_CHG_LSB 16

// Reset values
`define HSLD_CTRL_RST 1'h0
`define HSLD_OVR_RST 4'h0

// Resistor level codes from the analog sense front end
`define HSLD_LVL_200K_PD 3'h0
`define HSLD_LVL_200K_PU 3'h1
`define HSLD_LVL_10K_PD 3'h2
`define HSLD_LVL_10K_PU 3'h3
`define HSLD_LVL_10R_PD 3'h4

// Cycles after reset release before the first capture
`define HSLD_SETTLE_CYCLES 2'h3

// Avalon response codes
`define HSLD_RESP_OK 2'h0
`define HSLD_RESP_DECERR 2'h3

`endif

// [hsld_sync.v]
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Pins are quasi-static straps or a reset level.
// Notes: First stage feeds only the second stage.
module hsld_sync #(
	parameter W = 1
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Levels
	input wire [W-1:0] pin_in,
	output reg [W-1:0] pin_sync_q
);

reg [W-1:0] meta_q;

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		meta_q <= {W{1'b0}};
		pin_sync_q <= {W{1'b0}};
	end else begin
		meta_q <= pin_in;
		pin_sync_q <= meta_q;
	end
end

endmodule // hsld_sync

// [hsld_level_dec.v]
// Purpose: Five-level resistor strap to port-count mask decoder.
// Assumes: Level code comes from a settled, latched strap.
// Notes: Unknown codes fall back to the empty mask.
`include "hsld_defines.vh"
module hsld_level_dec (
	// Latched level code
	input wire [2:0] level,
	// Decoded port mask, port 1 in bit 0
	output reg [3:0] port_mask,
	output reg level_bad
);

always @* begin
	level_bad = 1'b0;
	case (level)
		`HSLD_LVL_200K_PD: port_mask = 4'h0;
		`HSLD_LVL_200K_PU: port_mask = 4'h1;
		`HSLD_LVL_10K_PD: port_mask = 4'h3;
		`HSLD_LVL_10K_PU: port_mask = 4'h7;
		`HSLD_LVL_10R_PD: port_mask = 4'hF;
		default: begin
			port_mask = 4'h0;
			level_bad = 1'b1;
		end
	endcase
end

endmodule // hsld_level_dec

// [hsld_strap_latch.v]
// Purpose: Latches the hub configuration straps and holds the decoded defaults.
// Assumes: Multi-level straps arrive as resistor level codes from an analog
//   front end; all strap pins and the external reset are asynchronous.
// Notes: Software may override the port disable, non-removable and charging masks over Avalon-MM.
//
// The register addresses and the Avalon-MM register port are this design's own decisions.
`include "hsld_defines.vh"
module hsld_strap_latch (
	// Clock and reset
	input wire clk_sys,
	input wire rst_b,
	// External chip reset pin
	input wire ext_reset_b,
	// Line disable straps, port 1 in bit 0
	input wire [3:0] port_plus_line_disable_strap,
	input wire [3:0] port_minus_line_disable_strap,
	// Multi-level straps as resistor level codes
	input wire [2:0] fixed_port_count_strap,
	input wire [2:0] charging_port_count_strap,
	input wire [2:0] mode_strap1,
	input wire [2:0] mode_strap2,
	input wire [2:0] mode_strap3,
	// Avalon-MM slave
	input wire [4:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg [1:0] avs_response,
	output reg avs_waitrequest,
	// Effective configuration
	output reg [3:0] plus_line_disable_q,
	output reg [3:0] minus_line_disable_q,
	output reg [3:0] port_disable_q,
	output reg [3:0] ss_port_disable_q,
	output reg [3:0] non_removable_mask_q,
	output reg [3:0] charging_port_mask_q,
	output reg [1:0] pin_setup_sel_q,
	output reg mode_reserved_q,
	output reg straps_valid_q
);

// Pin setup 1..4 decode, reserved flag in bit 2
function [2:0] mode_dec;
	input [2:0] s2;
	input [2:0] s1;
	begin
		if (s2 == `HSLD_LVL_200K_PD && s1 <= `HSLD_LVL_10K_PU)
			mode_dec = {1'b0, s1[1:0]};
		else
			mode_dec = 3'h4;
	end
endfunction

// Software value when override is on, else the strap default
function [3:0] ovr_pick;
	input en;
	input [3:0] sw_val;
	input [3:0] strap_val;
	begin
		ovr_pick = en ? sw_val : strap_val;
	end
endfunction

// Reset release
// Release is synchronised; assertion stays asynchronous
reg rst_meta_q;
reg rst_n;

always @(posedge clk_sys or negedge rst_b) begin
	if (!rst_b) begin
		rst_meta_q <= 1'b0;
		rst_n <= 1'b0;
	end else begin
		rst_meta_q <= 1'b1;
		rst_n <= rst_meta_q;
	end
end

// Synchronised pins, reset pin on top of the bus
localparam PIN_W = 24;
localparam PIN_MINUS_LSB = 4;
localparam PIN_FIXED_LSB = 8;
localparam PIN_CHG_LSB = 11;
localparam PIN_MODE_LSB = 14;
localparam PIN_EXT_BIT = 23;
wire [PIN_W-1:0] pins_raw;
wire [PIN_W-1:0] pins_s;
wire ext_reset_s;
wire [3:0] plus_s;
wire [3:0] minus_s;
wire [2:0] fixed_s;
wire [2:0] chg_s;
wire [8:0] mode_s;

assign pins_raw = {ext_reset_b, mode_strap3, mode_strap2, mode_strap1,
	charging_port_count_strap, fixed_port_count_strap,
	port_minus_line_disable_strap, port_plus_line_disable_strap};

hsld_sync #(
	.W(PIN_W)
) u_sync (
	.clk_sys(clk_sys),
	.rst_n(rst_n),
	.pin_in(pins_raw),
	.pin_sync_q(pins_s)
);

assign plus_s = pins_s[3:0];
assign minus_s = pins_s[PIN_MINUS_LSB +: 4];
assign fixed_s = pins_s[PIN_FIXED_LSB +: 3];
assign chg_s = pins_s[PIN_CHG_LSB +: 3];
assign mode_s = pins_s[PIN_MODE_LSB +: 9];
// Sync clears to zero, so the reset pin reads low just after release;
// the power-on settle count masks that false rising edge
assign ext_reset_s = pins_s[PIN_EXT_BIT];

// Capture events
reg [1:0] settle_cnt_q;
reg por_done_q;
reg ext_reset_prev_q;
wire por_capture;
wire ext_capture;
wire capture;

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		settle_cnt_q <= 2'h0;
		por_done_q <= 1'b0;
		ext_reset_prev_q <= 1'b1;
	end else begin
		ext_reset_prev_q <= ext_reset_s;
		if (!por_done_q) begin
			settle_cnt_q <= settle_cnt_q + 2'h1;
			if (settle_cnt_q == `HSLD_SETTLE_CYCLES - 2'h1)
				por_done_q <= 1'b1;
		end
	end
end

// Wait for the synchroniser to flush the reset zeros
// power-on capture point
assign por_capture = !por_done_q && settle_cnt_q == `HSLD_SETTLE_CYCLES - 2'h1;
assign ext_capture = por_done_q && ext_reset_s && !ext_reset_prev_q;
// Both events share one latch path, so every strap moves together
assign capture = por_capture || ext_capture;

// Latched strap image
reg [3:0] plus_lat_q;
reg [3:0] minus_lat_q;
reg [2:0] fixed_lat_q;
reg [2:0] chg_lat_q;
reg [8:0] mode_lat_q;
reg valid_lat_q;
reg [7:0] capture_cnt_q;

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		plus_lat_q <= 4'h0;
		minus_lat_q <= 4'h0;
		fixed_lat_q <= `HSLD_LVL_200K_PD;
		chg_lat_q <= `HSLD_LVL_200K_PD;
		mode_lat_q <= 9'h000;
		valid_lat_q <= 1'b0;
		capture_cnt_q <= 8'h00;
	end else if (capture) begin
		plus_lat_q <= plus_s;
		minus_lat_q <= minus_s;
		fixed_lat_q <= fixed_s;
		chg_lat_q <= chg_s;
		mode_lat_q <= mode_s;
		valid_lat_q <= 1'b1;
		// Wraps; software compares two reads to spot a new capture
		capture_cnt_q <= capture_cnt_q + 8'h01;
	end
end

// Decoders
wire [3:0] fixed_mask;
wire fixed_bad;
wire [3:0] chg_mask;
wire chg_bad;
wire [2:0] mode_word;
wire [3:0] strap_port_dis;

hsld_level_dec u_fixed_dec (
	.level(fixed_lat_q),
	.port_mask(fixed_mask),
	.level_bad(fixed_bad)
);

hsld_level_dec u_chg_dec (
	.level(chg_lat_q),
	.port_mask(chg_mask),
	.level_bad(chg_bad)
);

assign mode_word = mode_dec(mode_lat_q[5:3], mode_lat_q[2:0]);

assign strap_port_dis = plus_lat_q & minus_lat_q;

// Register file
reg ovr_en_q;
reg [3:0] ovr_port_q;
reg [3:0] ovr_fixed_q;
reg [3:0] ovr_chg_q;
reg [31:0] rd_word;
reg rd_hit;
wire req;
wire ack;
wire wr_ack;
wire [31:0] strap_word;
wire [31:0] cfg_word;

assign req = avs_read || avs_write;
assign ack = req && !avs_waitrequest;
assign wr_ack = avs_write && !avs_waitrequest;

// Raw latched codes, for reading back what the board strapped
assign strap_word = {5'h00, mode_lat_q[8:6], 1'b0, mode_lat_q[5:3], 1'b0, mode_lat_q[2:0],
	1'b0, chg_lat_q, 1'b0, fixed_lat_q, minus_lat_q, plus_lat_q};
assign cfg_word = {capture_cnt_q, 1'b0, !ext_reset_s, valid_lat_q, chg_bad, fixed_bad,
	mode_word[2], mode_word[1:0], charging_port_mask_q, non_removable_mask_q,
	ss_port_disable_q, port_disable_q};

always @* begin
	rd_hit = 1'b1;
	case (avs_address)
		`HSLD_ADDR_CTRL: rd_word = {31'h00000000, ovr_en_q};
		`HSLD_ADDR_OVR: rd_word = {12'h000, ovr_chg_q, 4'h0, ovr_fixed_q, 4'h0, ovr_port_q};
		`HSLD_ADDR_STRAP: rd_word = strap_word;
		`HSLD_ADDR_CFG: rd_word = cfg_word;
		default: begin
			rd_word = 32'h00000000;
			rd_hit = 1'b0;
		end
	endcase
end

// One wait cycle, then a single answer cycle
// A request still held at the answer edge lands in the else branch and rearms wait
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		avs_waitrequest <= 1'b1;
		avs_readdata <= 32'h00000000;
		avs_response <= `HSLD_RESP_OK;
	end else if (req && avs_waitrequest) begin
		avs_waitrequest <= 1'b0;
		avs_readdata <= avs_read ? rd_word : 32'h00000000;
		avs_response <= rd_hit ? `HSLD_RESP_OK : `HSLD_RESP_DECERR;
	end else begin
		avs_waitrequest <= 1'b1;
		if (ack)
			avs_readdata <= 32'h00000000;
	end
end

// Overrides change only the effective outputs, never the latch
always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		ovr_en_q <= `HSLD_CTRL_RST;
		ovr_port_q <= `HSLD_OVR_RST;
		ovr_fixed_q <= `HSLD_OVR_RST;
		ovr_chg_q <= `HSLD_OVR_RST;
	end else if (wr_ack) begin
		if (avs_address == `HSLD_ADDR_CTRL && avs_byteenable[0])
			ovr_en_q <= avs_writedata[`HSLD_CTRL_OVR_EN];
		if (avs_address == `HSLD_ADDR_OVR) begin
			if (avs_byteenable[0])
				ovr_port_q <= avs_writedata[`HSLD_OVR_PORT_LSB +: 4];
			if (avs_byteenable[1])
				ovr_fixed_q <= avs_writedata[`HSLD_OVR_FIXED_LSB +: 4];
			if (avs_byteenable[2])
				ovr_chg_q <= avs_writedata[`HSLD_OVR_CHG_LSB +: 4];
		end
	end
end

// Effective configuration
wire [3:0] eff_port_dis;
wire [3:0] eff_fixed;
wire [3:0] eff_chg;

assign eff_port_dis = ovr_pick(ovr_en_q, ovr_port_q, strap_port_dis);
assign eff_fixed = ovr_pick(ovr_en_q, ovr_fixed_q, fixed_mask);
assign eff_chg = ovr_pick(ovr_en_q, ovr_chg_q, chg_mask);

always @(posedge clk_sys or negedge rst_n) begin
	if (!rst_n) begin
		plus_line_disable_q <= 4'h0;
		minus_line_disable_q <= 4'h0;
		port_disable_q <= 4'h0;
		ss_port_disable_q <= 4'h0;
		non_removable_mask_q <= 4'h0;
		charging_port_mask_q <= 4'h0;
		pin_setup_sel_q <= 2'h0;
		mode_reserved_q <= 1'b0;
		straps_valid_q <= 1'b0;
	end else begin
		// Line disables are never overridden; software acts per port only
		// high plus strap disables the line
		plus_line_disable_q <= plus_lat_q;
		// high minus strap disables the line
		minus_line_disable_q <= minus_lat_q;
		port_disable_q <= eff_port_dis;
		// SuperSpeed path follows the legacy path
		ss_port_disable_q <= eff_port_dis;
		// non-removable ports reported to the host
		non_removable_mask_q <= eff_fixed;
		charging_port_mask_q <= eff_chg;
		// reserved combinations fall back to setup 1
		pin_setup_sel_q <= mode_word[1:0];
		mode_reserved_q <= mode_word[2];
		straps_valid_q <= valid_lat_q;
	end
end

endmodule // hsld_strap_latch

// [hsld_props.sv]
// Purpose: Bus and latch relations of the strap latch.
// Assumes: Bound to hsld_strap_latch.
// Notes: Port pairing check assumes override is off at capture.
module hsld_props (
	// Clock, reset, reset pin
	input logic clk_sys,
	input logic rst_b,
	input logic ext_reset_b,
	// Register bus
	input logic [4:0] avs_address,
	input logic avs_read,
	input logic avs_write,
	input logic [31:0] avs_readdata,
	input logic [1:0] avs_response,
	input logic avs_waitrequest,
	// Configuration
	input logic [3:0] plus_line_disable_q,
	input logic [3:0] minus_line_disable_q,
	input logic [3:0] port_disable_q,
	input logic [3:0] ss_port_disable_q,
	input logic [1:0] pin_setup_sel_q,
	input logic mode_reserved_q,
	input logic straps_valid_q
);
	logic [3:0] since_q;
	logic req;
	logic mapped;
	assign req = (avs_read | avs_write) & avs_waitrequest;
	assign mapped = avs_address inside {5'h00, 5'h04, 5'h08, 5'h0C};
	// Cycles since reset pin high, saturating
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			since_q <= 4'h0;
		else if (!ext_reset_b)
			since_q <= 4'h0;
		else if (since_q != 4'hF)
			since_q <= since_q + 4'h1;
	end
	// Local copy of the two-flop release, plus one edge of margin
	logic [2:0] rel_q;
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b)
			rel_q <= 3'h0;
		else
			rel_q <= {rel_q[1:0], 1'b1};
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rel_q[2]);
	a_ss_follow: assert property (ss_port_disable_q == port_disable_q)
		else $error("ss disable differs");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("wait low too long");
	a_req_answer: assert property (req |=> !avs_waitrequest)
		else $error("no answer");
	a_unmapped_err: assert property (req && !mapped |=> avs_response == 2'h3 && avs_readdata == 32'h0)
		else $error("unmapped answer");
	a_mapped_ok: assert property (req && mapped |=> avs_response == 2'h0)
		else $error("mapped response");
	a_latch_hold: assert property (since_q == 4'hF && $past(straps_valid_q) |->
		$stable(plus_line_disable_q) && $stable(minus_line_disable_q)) else $error("latch moved");
	a_port_pair: assert property ($changed(plus_line_disable_q) |->
		port_disable_q == (plus_line_disable_q & minus_line_disable_q)) else $error("port pair");
	a_mode_zero: assert property (mode_reserved_q |-> pin_setup_sel_q == 2'h0)
		else $error("reserved setup");
	cover property (req && avs_write);
	cover property ($rose(ext_reset_b));
	cover property (mode_reserved_q);
endmodule // hsld_props

bind hsld_strap_latch hsld_props u_props (.*);

// [hsld_board.sv]
// Purpose: Board straps and reset source.
// Assumes: Bench holds val steady between go pulses.
// Notes: Pins invert once idle, standing in for their other uses.
module hsld_board (
	// Clock and command
	input logic clk_sys,
	input logic go,
	output logic busy,
	// Strap levels and reset pin
	input logic [22:0] val,
	output logic [22:0] pins,
	output logic ext_reset_b
);
	logic [4:0] cnt = 5'h00;
	logic run = 1'b0;
	always @(posedge clk_sys) begin
		if (go) begin
			cnt <= 5'h00;
			run <= 1'b1;
		end else if (cnt != 5'h14)
			cnt <= cnt + 5'h01;
	end
	assign busy = cnt != 5'h14;
	assign ext_reset_b = !(run && cnt < 5'h04);
	assign pins = busy ? val : ~val;
endmodule // hsld_board

// [hsld_tb.sv]
// Purpose: Self-checking bench of the strap latch.
// Assumes: Override off whenever straps are captured.
// Notes: Board model drives straps and reset pin.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys, rst_b, go, busy, ext_reset_b, avs_read, avs_write, avs_waitrequest;
	logic straps_valid_q, mode_reserved_q;
	logic [4:0] avs_address;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic [3:0] avs_byteenable, plus_line_disable_q, minus_line_disable_q, port_disable_q, pl, mi;
	logic [3:0] ss_port_disable_q, non_removable_mask_q, charging_port_mask_q;
	logic [1:0] avs_response, pin_setup_sel_q, rs;
	logic [2:0] fx, cg, m1, m2, m3;
	logic [22:0] pins;
	logic [7:0] caps;
	int err_count = 0;
	int checks_done = 0;
	hsld_board u_board (.clk_sys, .go, .busy, .val({m3, m2, m1, cg, fx, mi, pl}), .pins, .ext_reset_b);
	hsld_strap_latch u_dut (.clk_sys, .rst_b, .ext_reset_b, .port_plus_line_disable_strap(pins[3:0]),
		.port_minus_line_disable_strap(pins[7:4]), .fixed_port_count_strap(pins[10:8]),
		.charging_port_count_strap(pins[13:11]), .mode_strap1(pins[16:14]), .mode_strap2(pins[19:17]),
		.mode_strap3(pins[22:20]), .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
		.avs_readdata, .avs_response, .avs_waitrequest, .plus_line_disable_q, .minus_line_disable_q,
		.port_disable_q, .ss_port_disable_q, .non_removable_mask_q, .charging_port_mask_q,
		.pin_setup_sel_q, .mode_reserved_q, .straps_valid_q);
	// board reference stands in as the system clock
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	function automatic logic [3:0] th(input logic [2:0] c);
		th = (c < 3'h5) ? 4'((5'h01 << c) - 5'h01) : 4'h0;
	endfunction
	task summarize;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask
	task tmo(input int n);
		if (n >= 60) begin
			err_count++;
			summarize();
		end
	endtask
	task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= w;
		avs_read <= !w;
		do begin
			@(posedge clk_sys);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 60);
		rd = avs_readdata;
		rs = avs_response;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		tmo(n);
	endtask
	task wait_idle;
		int n;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (busy !== 1'b0 && n < 60);
		tmo(n);
	endtask
	task check_all;
		logic res;
		res = (m2 != 3'h0) || (m1 > 3'h3);
		chk("valid", straps_valid_q, 1'b1);
		chk("plus", plus_line_disable_q, pl);
		chk("minus", minus_line_disable_q, mi);
		chk("port", port_disable_q, pl & mi);
		chk("ss", ss_port_disable_q, pl & mi);
		chk("nonrem", non_removable_mask_q, th(fx));
		chk("chg", charging_port_mask_q, th(cg));
		chk("setup", pin_setup_sel_q, res ? 2'h0 : m1[1:0]);
		chk("reserved", mode_reserved_q, res);
		bus(1'b0, 5'h08, 32'h0);
		chk("strap", rd, {5'h0, m3, 1'b0, m2, 1'b0, m1, 1'b0, cg, 1'b0, fx, mi, pl});
		bus(1'b0, 5'h0C, 32'h0);
		chk("cfg", rd[21:0], {1'b1, cg > 3'h4, fx > 3'h4, res, res ? 2'h0 : m1[1:0], th(cg), th(fx), pl & mi, pl & mi});
		chk("count", rd[31:22], {caps, 2'h0});
		chk("resp", rs, 2'h0);
	endtask
	initial begin
		rst_b = 1'b0;
		go = 1'b0;
		avs_address = 5'h00;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
		avs_byteenable = 4'hF;
		caps = 8'h01;
		{m3, m2, m1, cg, fx, mi, pl} = {3'h5, 3'h0, 3'h3, 3'h4, 3'h2, 4'h6, 4'hA};
		repeat (4) @(posedge clk_sys);
		rst_b <= 1'b1;
		wait_idle();
		check_all();
		bus(1'b0, 5'h00, 32'h0);
		chk("ctrl rst", rd, 32'h0);
		bus(1'b1, 5'h04, 32'h0001_0305);
		bus(1'b1, 5'h00, 32'h1);
		bus(1'b0, 5'h00, 32'h0);
		chk("ctrl set", rd, 32'h1);
		chk("ovr port", port_disable_q, 4'h5);
		chk("ovr ss", ss_port_disable_q, 4'h5);
		chk("ovr nonrem", non_removable_mask_q, 4'h3);
		chk("ovr chg", charging_port_mask_q, 4'h1);
		chk("ovr plus", plus_line_disable_q, pl);
		bus(1'b1, 5'h00, 32'h0);
		bus(1'b0, 5'h10, 32'h0);
		chk("unmap resp", rs, 2'h3);
		chk("unmap data", rd, 32'h0);
		for (int i = 0; i < 8; i++) begin
			@(posedge clk_sys);
			{m3, m2, m1, cg, fx, mi, pl} <= {3'(7 - i), (i == 2) ? 3'h1 : 3'h0, 3'(i), 3'(7 - i), 3'(i), 4'(i ^ 5), 4'(i)};
			go <= 1'b1;
			@(posedge clk_sys);
			go <= 1'b0;
			caps = caps + 8'h01;
			wait_idle();
			check_all();
		end
		summarize();
	end
endmodule // testbench
